// file: inc/cal_pkg.sv
// Constants and types shared by the calendar context keeper
package cal_pkg;
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          CTX_BYTES    = 5;
  localparam int          RD_LAG       = 1;
  localparam int          RD_LAST      = 2 * CTX_BYTES + RD_LAG;
  localparam int          SHUT_DELAY   = 8;
  localparam int          PRESCALE_W   = 15;
  localparam int          CNT_W        = 40;
  localparam int          SEC_SHIFT    = 7;
  localparam int          ELAPSED_W    = CNT_W - SEC_SHIFT;
  localparam logic [14:0] PRESCALE_TOP = 15'h7fff;
  localparam logic [7:0]  MATCH_BASE   = 8'h48;
  localparam logic [7:0]  COUNT_BASE   = 8'h40;
  // Wishbone register offsets
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_LTIME    = 8'h04;
  localparam logic [7:0]  REG_LDATE    = 8'h08;
  localparam logic [7:0]  REG_STATUS   = 8'h0c;
  localparam logic [7:0]  REG_TIME     = 8'h10;
  localparam logic [7:0]  REG_DATE     = 8'h14;
  localparam int          CTRL_LOAD    = 0;
  // Hours byte: bit 6 twelve-hour mode, bit 5 afternoon, bits 4:0 BCD 1..12
  localparam int          HR_12H_BIT   = 6;
  localparam int          HR_PM_BIT    = 5;
  localparam logic [4:0]  HR_ELEVEN    = 5'h11;
  localparam logic [4:0]  HR_TWELVE    = 5'h12;
  localparam logic [4:0]  HR_ONE       = 5'h01;
  localparam logic [7:0]  BCD_59       = 8'h59;
  localparam logic [7:0]  BCD_99       = 8'h99;
  localparam logic [7:0]  MONTH_LAST   = 8'h12;
  localparam logic [7:0]  FIRST_DAY    = 8'h01;
  localparam logic [7:0]  WDAY_LAST    = 8'h06;
  localparam logic [7:0]  DEF_YEAR     = 8'h06;
  localparam logic [7:0]  DEF_MONTH    = 8'h02;
  localparam logic [7:0]  DEF_DATE     = 8'h28;
  localparam logic [7:0]  DEF_WDAY     = 8'h02;
  localparam logic [7:0]  DEF_HOURS    = 8'h71;
  localparam logic [7:0]  DEF_MIN      = 8'h59;
  localparam logic [7:0]  DEF_SEC      = 8'h45;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] wday;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } cal_s;

  // Context as saved in the 40-bit match register, low byte first
  typedef struct packed {
    logic [7:0] year;
    logic [3:0] month;
    logic [5:0] date;
    logic [2:0] wday;
    logic       pm;
    logic [3:0] hour;
    logic [6:0] minutes;
    logic [6:0] seconds;
  } ctx_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wen;
  } cfg_bus_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef enum logic [2:0] {
    ST_WAIT_INIT,
    ST_RUN,
    ST_SAVE,
    ST_OFF,
    ST_RESTORE,
    ST_CATCHUP
  } ctx_state_e;
endpackage : cal_pkg

// file: verilog/shutdown_delay.sv
// Shift register that holds back the core power-off request
`timescale 1ns/10ps
module shutdown_delay #(
  parameter int DEPTH = cal_pkg::SHUT_DELAY
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Request and delayed output
  input  wire logic req_i,
  output logic      off_o
);
  import cal_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0] sr;
  } sd_state_s;

  sd_state_s sd_r;
  sd_state_s sd_nxt;

  // A dropped request clears at once so the core is not cut after wake
  always_comb begin
    sd_nxt = sd_r;
    if (req_i) begin
      sd_nxt.sr = {sd_r.sr[DEPTH-2:0], 1'b1};
    end else begin
      sd_nxt.sr = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sd_r <= '0;
    end else begin
      sd_r <= sd_nxt;
    end
  end

  assign off_o = sd_r.sr[DEPTH-1];
endmodule : shutdown_delay

// file: verilog/calendar_keeper.sv
// BCD calendar that saves and restores its context through the counter
`timescale 1ns/10ps
module calendar_keeper (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire cal_pkg::wb_req_s  wb_i,
  output cal_pkg::wb_rsp_s       wb_o,
  // Power and wake control
  input  wire logic              init_done_i,
  input  wire logic              power_down_n_i,
  input  wire logic              wake_n_i,
  input  wire logic              xtal_tick_i,
  output logic                   regulator_off_o,
  output logic                   rtc_act_o,
  output logic                   one_second_tick_o,
  // Counter configuration bus
  output cal_pkg::cfg_bus_s      cfg_bus_o,
  input  wire logic [7:0]        cfg_bus_rdata_i,
  // Display fields
  output logic [7:0]             rtc_year_o,
  output logic [7:0]             rtc_month_o,
  output logic [7:0]             rtc_date_o,
  output logic [7:0]             rtc_wday_o,
  output logic [7:0]             rtc_hours_o,
  output logic [7:0]             rtc_minutes_o,
  output logic [7:0]             rtc_seconds_o
);
  import cal_pkg::*;

  typedef struct packed {
    ctx_state_e             state;
    cal_s                   cal;
    cal_s                   load;
    logic [PRESCALE_W-1:0]  crystal_prescale_count;
    logic                   tick;
    logic [3:0]             idx;
    logic [8*RD_LAST-9:0]   rbuf;
    logic [ELAPSED_W-1:0]   elapsed;
    cfg_bus_s               cfg;
    logic                   ack;
    logic [31:0]            rdat;
    logic                   act;
  } st_s;

  localparam cal_s DEF_CAL = '{DEF_YEAR, DEF_MONTH, DEF_DATE, DEF_WDAY,
                               DEF_HOURS, DEF_MIN, DEF_SEC};

  st_s         r;
  st_s         n;
  logic        wb_hit;
  logic        wb_wr;
  logic        load_req;
  logic [31:0] tw;
  logic [31:0] dw;
  logic [39:0] ctx_word;
  ctx_s        ctx_in;
  logic        off_req;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction : bcd_inc

  function automatic logic [3:0] to_bin(input logic [4:0] b);
    to_bin = b[4] ? 4'(b[3:0] + 4'd10) : b[3:0];
  endfunction : to_bin

  function automatic logic [4:0] to_bcd(input logic [3:0] v);
    to_bcd = (v >= 4'd10) ? {1'b1, 4'(v - 4'd10)} : {1'b0, v};
  endfunction : to_bcd

  function automatic logic leap(input logic [7:0] y);
    if (y[4]) begin
      leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : leap

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    case (m)
      8'h02:   last_day = leap(y) ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction : last_day

  // Twelve-hour clock: 11 to 12 flips afternoon, 12 wraps to 1
  function automatic logic [7:0] hour_inc(input logic [7:0] h);
    hour_inc = h;
    if (h[4:0] == HR_TWELVE) begin
      hour_inc[4:0] = HR_ONE;
    end else if (h[4:0] == HR_ELEVEN) begin
      hour_inc[4:0]         = HR_TWELVE;
      hour_inc[HR_PM_BIT]   = ~h[HR_PM_BIT];
    end else begin
      hour_inc[4:0] = 5'(bcd_inc({3'h0, h[4:0]}));
    end
  endfunction : hour_inc

  function automatic cal_s next_sec(input cal_s c);
    next_sec = c;
    if (c.seconds != BCD_59) begin
      next_sec.seconds = bcd_inc(c.seconds);
    end else begin
      next_sec.seconds = '0;
      if (c.minutes != BCD_59) begin
        next_sec.minutes = bcd_inc(c.minutes);
      end else begin
        next_sec.minutes = '0;
        next_sec.hours   = hour_inc(c.hours);
        if (c.hours[HR_PM_BIT] && c.hours[4:0] == HR_ELEVEN) begin
          next_sec.wday = (c.wday == WDAY_LAST) ? '0 : bcd_inc(c.wday);
          if (c.date != last_day(c.month, c.year)) begin
            next_sec.date = bcd_inc(c.date);
          end else begin
            next_sec.date = FIRST_DAY;
            if (c.month != MONTH_LAST) begin
              next_sec.month = bcd_inc(c.month);
            end else begin
              next_sec.month = FIRST_DAY;
              next_sec.year  = (c.year == BCD_99) ? '0 : bcd_inc(c.year);
            end
          end
        end
      end
    end
  endfunction : next_sec

  // Context packing for the match register
  assign ctx_word = {r.cal.year, to_bin(r.cal.month[4:0]), r.cal.date[5:0],
                     r.cal.wday[2:0], r.cal.hours[HR_PM_BIT],
                     to_bin(r.cal.hours[4:0]), r.cal.minutes[6:0],
                     r.cal.seconds[6:0]};
  assign ctx_in   = ctx_s'(r.rbuf[39:0]);
  assign wb_hit   = wb_i.cyc && wb_i.stb && !r.ack;
  assign wb_wr    = wb_hit && wb_i.we;
  assign load_req = wb_wr && wb_i.adr == REG_CTRL && wb_i.sel[0]
                    && wb_i.dat[CTRL_LOAD];
  assign off_req  = (r.state == ST_SAVE) || (r.state == ST_OFF);

  always_comb begin
    n          = r;
    n.ack      = 1'b0;
    n.tick     = 1'b0;
    n.cfg.wen  = 1'b0;
    tw         = {8'h00, r.load[23:0]};
    dw         = r.load[55:24];
    // Divide the crystal rate down to one pulse per second
    if (xtal_tick_i) begin
      n.crystal_prescale_count = r.crystal_prescale_count + 15'h0001;
      n.tick = (r.crystal_prescale_count == PRESCALE_TOP);
    end
    // Register access: answer one cycle after the request
    if (wb_hit) begin
      n.ack = 1'b1;
      case (wb_i.adr)
        REG_LTIME:  n.rdat = tw;
        REG_LDATE:  n.rdat = dw;
        REG_STATUS: n.rdat = {28'h000_0000, regulator_off_o,
                              r.state == ST_OFF, r.state == ST_CATCHUP, r.act};
        REG_TIME:   n.rdat = {8'h00, r.cal[23:0]};
        REG_DATE:   n.rdat = r.cal[55:24];
        default:    n.rdat = '0;
      endcase
    end
    if (wb_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_i.sel[b] && wb_i.adr == REG_LTIME && b < 3) begin
          tw[b*8 +: 8] = wb_i.dat[b*8 +: 8];
        end
        if (wb_i.sel[b] && wb_i.adr == REG_LDATE) begin
          dw[b*8 +: 8] = wb_i.dat[b*8 +: 8];
        end
      end
    end
    n.load = {dw, tw[23:0]};
    case (r.state)
      ST_WAIT_INIT: begin
        if (init_done_i) begin
          n.state = ST_RUN;
          n.act   = 1'b1;
        end
      end
      ST_RUN: begin
        if (!power_down_n_i) begin
          n.state = ST_SAVE;
          n.idx   = '0;
        end else if (load_req) begin
          n.cal = r.load;
        end else if (r.tick) begin
          n.cal = next_sec(r.cal);
        end
      end
      ST_SAVE: begin
        n.cfg.addr  = MATCH_BASE + 8'(r.idx);
        n.cfg.wdata = ctx_word[r.idx*8 +: 8];
        n.cfg.wen   = 1'b1;
        n.idx       = r.idx + 4'h1;
        if (r.idx == 4'(CTX_BYTES - 1)) begin
          n.state = ST_OFF;
        end
      end
      ST_OFF: begin
        if (!wake_n_i) begin
          n.state = ST_RESTORE;
          n.idx   = '0;
        end
      end
      ST_RESTORE: begin
        if (r.idx < 4'(CTX_BYTES)) begin
          n.cfg.addr = MATCH_BASE + 8'(r.idx);
        end else if (r.idx < 4'(2 * CTX_BYTES)) begin
          n.cfg.addr = COUNT_BASE + 8'(r.idx - 4'(CTX_BYTES));
        end
        if (r.idx >= 4'(RD_LAG) && r.idx < 4'(RD_LAST)) begin
          n.rbuf = {cfg_bus_rdata_i, r.rbuf[8*RD_LAST-9:8]};
        end
        n.idx = r.idx + 4'h1;
        if (r.idx == 4'(RD_LAST)) begin
          n.cal.year    = ctx_in.year;
          n.cal.month   = {3'h0, to_bcd(ctx_in.month)};
          n.cal.date    = {2'h0, ctx_in.date};
          n.cal.wday    = {5'h00, ctx_in.wday};
          n.cal.hours   = {1'b0, 1'b1, ctx_in.pm, to_bcd(ctx_in.hour)};
          n.cal.minutes = {1'b0, ctx_in.minutes};
          n.cal.seconds = {1'b0, ctx_in.seconds};
          n.elapsed     = r.rbuf[8*RD_LAST-9 -: ELAPSED_W];
          n.state       = ST_CATCHUP;
        end
      end
      ST_CATCHUP: begin
        // A live tick during catch-up offsets the step it would cost
        if (r.elapsed == '0) begin
          n.state = ST_RUN;
        end else begin
          n.cal = next_sec(r.cal);
          if (!r.tick) begin
            n.elapsed = r.elapsed - ELAPSED_W'(1);
          end
        end
      end
      default: n.state = ST_WAIT_INIT;
    endcase
  end

  // Synchronous active-high reset of the single clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r       <= '0;
      r.state <= ST_WAIT_INIT;
      r.cal   <= DEF_CAL;
      r.load  <= DEF_CAL;
    end else begin
      r <= n;
    end
  end

  shutdown_delay #(
    .DEPTH (SHUT_DELAY)
  ) u_shutdown_delay (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .req_i (off_req),
    .off_o (regulator_off_o)
  );

  assign wb_o              = '{ack: r.ack, dat: r.rdat};
  assign cfg_bus_o         = r.cfg;
  assign rtc_act_o         = r.act;
  assign one_second_tick_o = r.tick;
  assign rtc_year_o        = r.cal.year;
  assign rtc_month_o       = r.cal.month;
  assign rtc_date_o        = r.cal.date;
  assign rtc_wday_o        = r.cal.wday;
  assign rtc_hours_o       = r.cal.hours;
  assign rtc_minutes_o     = r.cal.minutes;
  assign rtc_seconds_o     = r.cal.seconds;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_wait_init_hold: assert property (
    (r.state == ST_WAIT_INIT && !init_done_i) |=> r.state == ST_WAIT_INIT && !rtc_act_o
  ) else $error("calendar left idle without init done");

  a_save_on_request: assert property (
    (r.state == ST_RUN && !power_down_n_i) |=> r.state == ST_SAVE ##5 r.state == ST_OFF
  ) else $error("power-off request did not start the save");

  a_save_in_seven: assert property (
    $rose(r.state == ST_SAVE) |-> ##[1:6] (cfg_bus_o.wen && cfg_bus_o.addr == MATCH_BASE + 8'h04)
  ) else $error("context save not finished in time");

  a_off_delayed: assert property (
    $rose(r.state == ST_SAVE) |-> (!regulator_off_o) [*8] ##1 regulator_off_o
  ) else $error("shutdown request not delayed by eight cycles");

  a_write_window: assert property (
    cfg_bus_o.wen |-> (cfg_bus_o.addr >= MATCH_BASE && cfg_bus_o.addr <= MATCH_BASE + 8'h04)
  ) else $error("write outside the match register");

  a_count_read: assert property (
    $rose(r.state == ST_RESTORE) |-> ##[1:11] (cfg_bus_o.addr == COUNT_BASE + 8'h04)
  ) else $error("elapsed counter not read on wake");

  a_wdata_seconds: assert property (
    (cfg_bus_o.wen && cfg_bus_o.addr == MATCH_BASE) |-> cfg_bus_o.wdata[6:0] == r.cal.seconds[6:0]
  ) else $error("first saved byte is not the seconds");

  a_tick_prescale: assert property (
    (xtal_tick_i && r.crystal_prescale_count == PRESCALE_TOP) |=> one_second_tick_o ##1 !one_second_tick_o
  ) else $error("one-second tick not made at prescaler wrap");

  a_reset_default: assert property (
    $fell(rst_i) |-> (rtc_hours_o == DEF_HOURS && rtc_date_o == DEF_DATE && rtc_wday_o == DEF_WDAY)
  ) else $error("calendar not at its default after reset");

  a_second_carry: assert property (
    (r.state == ST_RUN && power_down_n_i && !load_req && r.tick && r.cal.seconds == BCD_59)
      |=> (rtc_seconds_o == '0 && rtc_minutes_o != $past(rtc_minutes_o))
  ) else $error("seconds carry did not reach the minutes");

  a_ack_single: assert property (
    wb_o.ack |=> !wb_o.ack
  ) else $error("bus acknowledge held longer than one cycle");
endmodule : calendar_keeper

// file: tb/cfg_counter_model.sv
// Behavioural model of the elapsed-time counter behind the configuration bus
`timescale 1ns/10ps
module cfg_counter_model (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Configuration bus and core power state
  input  wire cal_pkg::cfg_bus_s cfg_bus_i,
  input  wire logic              regulator_off_i,
  output logic [7:0]             rdata_o
);
  import cal_pkg::*;
  logic [7:0]  match_r [5];
  logic [39:0] count_r;
  logic        off_r;
  logic        noise_r;
  logic        count_match_out;

  // Bus writes land on the shared system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      off_r   <= 1'b0;
      noise_r <= 1'b0;
    end else begin
      off_r   <= regulator_off_i;
      noise_r <= ~noise_r;
      // One second per clock while the core is off keeps runs short
      if (regulator_off_i && !off_r) begin
        count_r <= '0;
      end else if (regulator_off_i) begin
        count_r <= count_r + 40'h80;
      end
    end
    if (cfg_bus_i.wen && cfg_bus_i.addr[7:3] == 5'h09 && cfg_bus_i.addr[2:0] <= 3'h4) begin
      match_r[cfg_bus_i.addr[2:0]] <= cfg_bus_i.wdata;
    end
  end

  // Unmapped reads return a toggling pattern, not a stale byte
  always_comb begin
    rdata_o = {8{noise_r}};
    if (cfg_bus_i.addr[7:3] == 5'h09 && cfg_bus_i.addr[2:0] <= 3'h4) begin
      rdata_o = match_r[cfg_bus_i.addr[2:0]];
    end else if (cfg_bus_i.addr[7:3] == 5'h08 && cfg_bus_i.addr[2:0] <= 3'h4) begin
      rdata_o = count_r[{cfg_bus_i.addr[2:0], 3'h0} +: 8];
    end
  end

  // Match flag kept for completeness; the calendar has no input for it
  assign count_match_out = (count_r == {match_r[4], match_r[3], match_r[2], match_r[1],
                                        match_r[0]});
endmodule : cfg_counter_model

// file: tb/tb_calendar_keeper.sv
// Self-checking bench for the calendar context keeper
`timescale 1ns/10ps
module tb_calendar_keeper;
  import cal_pkg::*;
  logic        clk_i;
  logic        rst_i;
  wb_req_s     wb_i;
  wb_rsp_s     wb_o;
  logic        init_done_i;
  logic        power_down_n_i;
  logic        wake_n_i;
  logic        xtal_tick_i;
  logic        regulator_off_o;
  logic        rtc_act_o;
  logic        one_second_tick_o;
  cfg_bus_s    cfg_bus_o;
  logic [7:0]  cfg_bus_rdata_i;
  cal_s        cal_now;
  cal_s        e;
  logic [31:0] seed;
  logic [31:0] q;
  int          k;
  int          n_mismatch;
  int          checks;

  always #10 clk_i = ~clk_i;

  calendar_keeper uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
    .init_done_i(init_done_i), .power_down_n_i(power_down_n_i), .wake_n_i(wake_n_i),
    .xtal_tick_i(xtal_tick_i), .regulator_off_o(regulator_off_o), .rtc_act_o(rtc_act_o),
    .one_second_tick_o(one_second_tick_o), .cfg_bus_o(cfg_bus_o),
    .cfg_bus_rdata_i(cfg_bus_rdata_i), .rtc_year_o(cal_now.year),
    .rtc_month_o(cal_now.month), .rtc_date_o(cal_now.date), .rtc_wday_o(cal_now.wday),
    .rtc_hours_o(cal_now.hours), .rtc_minutes_o(cal_now.minutes),
    .rtc_seconds_o(cal_now.seconds)
  );

  cfg_counter_model u_model (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_bus_i(cfg_bus_o),
    .regulator_off_i(regulator_off_o), .rdata_o(cfg_bus_rdata_i)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic int d2b(logic [7:0] v);
    return v[7:4] * 10 + v[3:0];
  endfunction : d2b

  function automatic logic [7:0] b2d(int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction : b2d

  function automatic int mdays(int mo, int y);
    if (mo == 2) return (y % 4 == 0) ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
    return 31;
  endfunction : mdays

  function automatic cal_s next_sec(cal_s c);
    int   s, m, h, d, mo, y;
    logic pm;
    s  = d2b(c.seconds) + 1;
    m  = d2b(c.minutes) + s / 60;
    s  = s % 60;
    h  = d2b({3'h0, c.hours[4:0]}) + m / 60;
    m  = m % 60;
    pm = c.hours[5];
    d  = d2b(c.date);
    mo = d2b(c.month);
    y  = d2b(c.year);
    if (h == 12 && m == 0 && s == 0) begin
      pm = ~pm;
      if (!pm) begin
        c.wday = (c.wday == WDAY_LAST) ? 8'h00 : c.wday + 8'h01;
        d = d + 1;
        if (d > mdays(mo, y)) begin
          d  = 1;
          mo = mo + 1;
        end
        if (mo == 13) begin
          mo = 1;
          y  = (y + 1) % 100;
        end
      end
    end
    if (h == 13) h = 1;
    c.seconds = b2d(s);
    c.minutes = b2d(m);
    c.hours   = (pm ? 8'h60 : 8'h40) | b2d(h);
    c.date    = b2d(d);
    c.month   = b2d(mo);
    c.year    = b2d(y);
    return c;
  endfunction : next_sec

  function automatic logic [39:0] pack(cal_s c);
    ctx_s x;
    x = {c.year, 4'(d2b(c.month)), c.date[5:0], c.wday[2:0], c.hours[5],
         4'(d2b({3'h0, c.hours[4:0]})), c.minutes[6:0], c.seconds[6:0]};
    return x;
  endfunction : pack

  function automatic cal_s rcal();
    return {b2d(rnd() % 100), b2d(1 + rnd() % 12), b2d(1 + rnd() % 28), b2d(rnd() % 7),
            (rnd() % 2 ? 8'h60 : 8'h40) | b2d(1 + rnd() % 12), b2d(rnd() % 60),
            b2d(rnd() % 60)};
  endfunction : rcal

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  // Classic single cycle; read data lands in q
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    if (wb_o.ack !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    q = wb_o.dat;
    wb_i <= '0;
  endtask : wb

  task automatic run_trip(input cal_s c, input int off);
    logic [39:0] x;
    logic [7:0]  a [14];
    int          nw, w0, r, last, secs;
    x    = pack(c);
    nw   = 0;
    w0   = 0;
    r    = 0;
    last = 0;
    wb(1'b1, REG_LTIME, {8'h00, c.hours, c.minutes, c.seconds});
    wb(1'b1, REG_LDATE, c[55:24]);
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    wb(1'b0, REG_TIME, '0);
    chk("time reg", {8'h00, c.hours, c.minutes, c.seconds}, q);
    wb(1'b0, REG_DATE, '0);
    chk("date reg", c[55:24], q);
    chk("display", c, cal_now);
    power_down_n_i <= 1'b0;
    for (int i = 1; i <= 16; i++) begin
      @(posedge clk_i);
      if (cfg_bus_o.wen === 1'b1) begin
        chk("save addr", MATCH_BASE + 8'(nw), cfg_bus_o.addr);
        chk("save data", x[8*nw +: 8], cfg_bus_o.wdata);
        if (nw == 0) w0 = i;
        last = i;
        nw++;
      end
      if (regulator_off_o === 1'b1 && r == 0) r = i;
    end
    chk("save count", 5, nw);
    chk("save span", 1'b1, last <= 8);
    // Save state shows one cycle before its first byte
    chk("off delay", SHUT_DELAY, r - (w0 - 1));
    power_down_n_i <= 1'b1;
    wb(1'b0, REG_STATUS, '0);
    chk("off status", 32'h0000_000d, q);
    repeat (off) @(posedge clk_i);
    wake_n_i <= 1'b0;
    @(posedge clk_i);
    wake_n_i <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_i);
      a[i] = cfg_bus_o.addr;
      chk("restore wen", 1'b0, cfg_bus_o.wen);
    end
    k = 0;
    for (int i = 13; i >= 0; i--) if (a[i] == MATCH_BASE) k = i;
    for (int j = 0; j < 10; j++) begin
      chk("restore addr", (j < 5) ? MATCH_BASE + 8'(j) : COUNT_BASE + 8'(j - 5), a[k+j]);
    end
    secs = int'(u_model.count_r[39:7]);
    e    = c;
    repeat (secs) e = next_sec(e);
    repeat (secs + 12) @(posedge clk_i);
    chk("restored", e, cal_now);
    wb(1'b0, REG_STATUS, '0);
    chk("status", 32'h0000_0001, q);
  endtask : run_trip

  initial begin
    clk_i          = 1'b0;
    rst_i          = 1'b1;
    wb_i           = '0;
    init_done_i    = 1'b0;
    power_down_n_i = 1'b1;
    wake_n_i       = 1'b1;
    xtal_tick_i    = 1'b0;
    seed           = 32'h0000_46d0;
    n_mismatch     = 0;
    checks         = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset fields", {DEF_YEAR, DEF_MONTH, DEF_DATE, DEF_WDAY, DEF_HOURS, DEF_MIN, DEF_SEC},
        cal_now);
    wb(1'b0, REG_LTIME, '0);
    chk("load time", {8'h00, DEF_HOURS, DEF_MIN, DEF_SEC}, q);
    wb(1'b0, 8'h20, '0);
    chk("unmapped", 32'h0000_0000, q);
    power_down_n_i <= 1'b0;
    repeat (6) begin
      @(posedge clk_i);
      chk("idle wen", 1'b0, cfg_bus_o.wen);
      chk("idle act", 1'b0, rtc_act_o);
    end
    power_down_n_i <= 1'b1;
    init_done_i    <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("active", 1'b1, rtc_act_o);
    run_trip({8'h08, 8'h02, 8'h28, 8'h04, 8'h71, 8'h59, 8'h50}, 30);
    run_trip({8'h99, 8'h12, 8'h31, 8'h06, 8'h71, 8'h59, 8'h55}, 30);
    run_trip({8'h06, 8'h04, 8'h30, 8'h00, 8'h71, 8'h59, 8'h58}, 25);
    repeat (3) run_trip(rcal(), 20 + int'(rnd() % 200));
    // Preload 11:59:58 PM so the measured tick carries into March
    wb(1'b1, REG_LTIME, 32'h0071_5958);
    wb(1'b1, REG_LDATE, 32'h0602_2802);
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    xtal_tick_i <= 1'b1;
    k = 0;
    while (one_second_tick_o !== 1'b1 && k < 40000) begin
      @(posedge clk_i);
      k++;
    end
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
      if (k == 2) e = cal_now;
    end while (one_second_tick_o !== 1'b1 && k < 40000);
    chk("tick period", 32768, k);
    repeat (2) @(posedge clk_i);
    chk("tick step", next_sec(e), cal_now);
    test_done();
  end
endmodule : tb_calendar_keeper
